// [rtl/adc_regs_defs.vh]
/*
  Constants for the channel-control register bank: register offsets,
  field positions, mode and polarity codes, and the timing of the pulsed alert.
  Assumes it is included by its bare name into each design file that needs it.
*/
`ifndef ADC_REGS_DEFS_VH
`define ADC_REGS_DEFS_VH

// register offsets
`define ADDR_OUTPUT_LEVEL_SET   8'h0b
`define ADDR_INPUT_LEVEL        8'h0d
`define ADDR_SCAN_CONTROL       8'h10
`define ADDR_SINGLE_CH_SELECT   8'h11
`define ADDR_SCAN_CH_MASK       8'h12
`define ADDR_ALARM_CH_MASK      8'h14
`define ADDR_ALARM_SOURCE       8'h16
`define ADDR_ALARM_PIN_SETUP    8'h17

// reset value shared by every register of the bank
`define REG_RESET               8'h00

// scan_control fields
`define SCAN_GO_BIT             4
`define SCAN_METHOD_HI          1
`define SCAN_METHOD_LO          0
// single_channel_select fields
`define CH_ID_HI                3
`define CH_ID_LO                0
`define CH_ID_RSVD_BIT          3
// alarm_source_select fields
`define ALARM_CHECK_ERR_BIT     0
// alarm_pin_setup fields
`define ALARM_PIN_HI            7
`define ALARM_PIN_LO            4
`define ALARM_POL_HI            1
`define ALARM_POL_LO            0

// scan methods
`define METHOD_SINGLE           2'h0
`define METHOD_AUTO             2'h1
`define METHOD_ON_THE_FLY       2'h2
`define METHOD_RESERVED         2'h3

// alert output forms
`define POL_LEVEL_LOW           2'h0
`define POL_LEVEL_HIGH          2'h1
`define POL_PULSE_LOW           2'h2
`define POL_PULSE_HIGH          2'h3

// number of channels and last channel index
`define NUM_CH                  8
`define LAST_CH                 3'h7

// pulsed alert width, and clock rate
`define CLK_MHZ                 100
`define ALARM_PULSE_NS          1000
`define ALARM_PULSE_CYCLES      ((`ALARM_PULSE_NS * `CLK_MHZ + 999) / 1000)
`define PULSE_CNT_W             8

`endif

// [rtl/alarm_pin_shaper.v]
/*
  Shapes the internal alert into the form chosen by the polarity field:
  a level of either sense, or one pulse of either sense per rising alert.
  Assumes alert_in is synchronous to clk and that ce gates all state.
*/
`timescale 1ns/1ps
`include "adc_regs_defs.vh"

module alarm_pin_shaper (
  input wire clk,
  input wire reset,
  input wire ce,
  input wire alert_in,
  input wire [1:0] polarity,
  output reg pin_level
);

  localparam integer PULSE_LEN_I = `ALARM_PULSE_CYCLES;
  localparam [`PULSE_CNT_W-1:0] PULSE_LEN = PULSE_LEN_I[`PULSE_CNT_W-1:0];

  reg alert_d_r;
  reg [`PULSE_CNT_W-1:0] pulse_cnt_r;
  reg [`PULSE_CNT_W-1:0] pulse_cnt_nxt;
  reg pin_nxt;
  wire pulsing;

  assign pulsing = (pulse_cnt_r != {`PULSE_CNT_W{1'b0}});

  always @* begin
    pulse_cnt_nxt = pulse_cnt_r;
    if (alert_in && !alert_d_r) begin
      pulse_cnt_nxt = PULSE_LEN;
    end else if (pulsing) begin
      pulse_cnt_nxt = pulse_cnt_r - {{(`PULSE_CNT_W-1){1'b0}}, 1'b1};
    end
    case (polarity)
      `POL_LEVEL_LOW: pin_nxt = ~alert_in;
      `POL_LEVEL_HIGH: pin_nxt = alert_in;
      `POL_PULSE_LOW: pin_nxt = ~(pulse_cnt_nxt != {`PULSE_CNT_W{1'b0}});
      `POL_PULSE_HIGH: pin_nxt = (pulse_cnt_nxt != {`PULSE_CNT_W{1'b0}});
      default: pin_nxt = 1'b1;
    endcase
  end

  always @(posedge clk) begin
    if (reset) begin
      alert_d_r <= 1'b0;
      pulse_cnt_r <= {`PULSE_CNT_W{1'b0}};
      pin_level <= 1'b1;
    end else if (ce) begin
      alert_d_r <= alert_in;
      pulse_cnt_r <= pulse_cnt_nxt;
      pin_level <= pin_nxt;
    end
  end

endmodule // alarm_pin_shaper

// [rtl/adc_channel_regs.v]
/*
  Register bank for channel control: output levels, input readback,
  scan method and sequencing, single-channel select, scan and alarm masks,
  alarm sources and the alarm pin. Also the auto-scan channel stepper
  and the per-channel pin drive.
  Assumes a serial front end turns frames into one-cycle read and write
  strobes with an 8-bit address, and that pin type, pin direction, event
  flags and the input check error flag come from elsewhere in the device.
*/
`timescale 1ns/1ps
`include "adc_regs_defs.vh"

module adc_channel_regs (
  input wire clk,
  input wire reset,
  input wire ce,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  input wire [7:0] pin_type_bits,
  input wire [7:0] pin_dir_bits,
  input wire [7:0] pin_level_in,
  input wire [7:0] event_flags,
  input wire input_check_error_flag,
  input wire conv_done,
  input wire [3:0] on_the_fly_channel_id,
  output wire [7:0] pin_drive,
  output wire [7:0] pin_drive_en,
  output reg [3:0] conv_channel,
  output reg conv_channel_valid,
  output reg scan_running,
  output reg alarm_internal
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // next set mask bit above cur, wrapping; cur itself if it is the only one
  function [2:0] next_in_mask;
    input [2:0] cur;
    input [7:0] mask;
    integer k;
    reg [2:0] idx;
    reg found;
    begin
      next_in_mask = cur;
      found = 1'b0;
      for (k = 1; k <= `NUM_CH; k = k + 1) begin
        idx = cur + k[2:0];
        if (!found && mask[idx]) begin
          next_in_mask = idx;
          found = 1'b1;
        end
      end
    end
  endfunction

  function hit;
    input [7:0] addr;
    input [7:0] target;
    begin
      hit = (addr == target);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // registers

  reg [7:0] output_level_bits_r;
  reg [7:0] input_level_bits_r;
  reg scan_go_r;
  reg [1:0] scan_method_r;
  reg [3:0] single_channel_id_r;
  reg [7:0] scan_mask_r;
  reg [7:0] alarm_mask_r;
  reg alarm_on_input_check_error_r;
  reg [3:0] alarm_pin_r;
  reg [1:0] alarm_pol_r;

  always @(posedge clk) begin
    if (reset) begin
      output_level_bits_r <= `REG_RESET;
      input_level_bits_r <= `REG_RESET;
      scan_go_r <= 1'b0;
      scan_method_r <= `METHOD_SINGLE;
      single_channel_id_r <= 4'h0;
      scan_mask_r <= `REG_RESET;
      alarm_mask_r <= `REG_RESET;
      alarm_on_input_check_error_r <= 1'b0;
      alarm_pin_r <= 4'h0;
      alarm_pol_r <= `POL_LEVEL_LOW;
    end else if (ce) begin
      input_level_bits_r <= pin_level_in;
      if (reg_wr) begin
        // only documented fields are stored
        if (hit(reg_addr, `ADDR_OUTPUT_LEVEL_SET)) begin
          output_level_bits_r <= reg_wdata;
        end
        if (hit(reg_addr, `ADDR_SCAN_CONTROL)) begin
          scan_go_r <= reg_wdata[`SCAN_GO_BIT];
          scan_method_r <= reg_wdata[`SCAN_METHOD_HI:`SCAN_METHOD_LO];
        end
        if (hit(reg_addr, `ADDR_SINGLE_CH_SELECT)) begin
          single_channel_id_r <= reg_wdata[`CH_ID_HI:`CH_ID_LO];
        end
        if (hit(reg_addr, `ADDR_SCAN_CH_MASK)) begin
          scan_mask_r <= reg_wdata;
        end
        if (hit(reg_addr, `ADDR_ALARM_CH_MASK)) begin
          alarm_mask_r <= reg_wdata;
        end
        if (hit(reg_addr, `ADDR_ALARM_SOURCE)) begin
          alarm_on_input_check_error_r <= reg_wdata[`ALARM_CHECK_ERR_BIT];
        end
        if (hit(reg_addr, `ADDR_ALARM_PIN_SETUP)) begin
          alarm_pin_r <= reg_wdata[`ALARM_PIN_HI:`ALARM_PIN_LO];
          alarm_pol_r <= reg_wdata[`ALARM_POL_HI:`ALARM_POL_LO];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read port: registered data, zero for unmapped offsets

  reg [7:0] rdata_nxt;

  always @* begin
    case (reg_addr)
      `ADDR_OUTPUT_LEVEL_SET: rdata_nxt = output_level_bits_r;
      `ADDR_INPUT_LEVEL: rdata_nxt = input_level_bits_r;
      `ADDR_SCAN_CONTROL: rdata_nxt = {3'h0, scan_go_r, 2'h0, scan_method_r};
      `ADDR_SINGLE_CH_SELECT: rdata_nxt = {4'h0, single_channel_id_r};
      `ADDR_SCAN_CH_MASK: rdata_nxt = scan_mask_r;
      `ADDR_ALARM_CH_MASK: rdata_nxt = alarm_mask_r;
      `ADDR_ALARM_SOURCE: rdata_nxt = {7'h00, alarm_on_input_check_error_r};
      `ADDR_ALARM_PIN_SETUP: rdata_nxt = {alarm_pin_r, 2'h0, alarm_pol_r};
      default: rdata_nxt = 8'h00;
    endcase
  end

  always @(posedge clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (ce && reg_rd) begin
      reg_rdata <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // channel selection and auto-scan stepper

  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_SCAN = 3'h2;
  localparam [2:0] ST_FIXED = 3'h4;

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [2:0] scan_ch_r;
  reg [2:0] scan_ch_nxt;
  reg [3:0] conv_channel_nxt;
  reg conv_valid_nxt;
  wire auto_on;

  assign auto_on = (scan_method_r == `METHOD_AUTO) && scan_go_r && (scan_mask_r != 8'h00);

  always @* begin
    state_nxt = state_r;
    scan_ch_nxt = scan_ch_r;
    case (state_r)
      ST_IDLE: begin
        if (auto_on) begin
          state_nxt = ST_SCAN;
          scan_ch_nxt = next_in_mask(`LAST_CH, scan_mask_r);
        end else if (scan_method_r != `METHOD_AUTO) begin
          state_nxt = ST_FIXED;
        end
      end
      ST_SCAN: begin
        if (!auto_on) begin
          state_nxt = ST_IDLE;
        end else if (conv_done || !scan_mask_r[scan_ch_r]) begin
          scan_ch_nxt = next_in_mask(scan_ch_r, scan_mask_r);
        end
      end
      ST_FIXED: begin
        if (scan_method_r == `METHOD_AUTO) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    case (scan_method_r)
      `METHOD_SINGLE: begin
        conv_channel_nxt = single_channel_id_r;
        conv_valid_nxt = ~single_channel_id_r[`CH_ID_RSVD_BIT];
      end
      `METHOD_AUTO: begin
        conv_channel_nxt = {1'b0, scan_ch_nxt};
        conv_valid_nxt = (state_nxt == ST_SCAN);
      end
      `METHOD_ON_THE_FLY: begin
        conv_channel_nxt = on_the_fly_channel_id;
        conv_valid_nxt = ~on_the_fly_channel_id[`CH_ID_RSVD_BIT];
      end
      default: begin
        conv_channel_nxt = 4'h0;
        conv_valid_nxt = 1'b0;
      end
    endcase
  end

  always @(posedge clk) begin
    if (reset) begin
      state_r <= ST_IDLE;
      scan_ch_r <= 3'h0;
      conv_channel <= 4'h0;
      conv_channel_valid <= 1'b0;
      scan_running <= 1'b0;
    end else if (ce) begin
      state_r <= state_nxt;
      scan_ch_r <= scan_ch_nxt;
      conv_channel <= conv_channel_nxt;
      conv_channel_valid <= conv_valid_nxt;
      scan_running <= (state_nxt == ST_SCAN);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // alert and pin drive

  wire alarm_nxt;
  wire alarm_pin_level;
  wire [7:0] digital_out;
  reg [7:0] alarm_route;
  integer i;

  assign alarm_nxt = (|(event_flags & alarm_mask_r))
                   | (alarm_on_input_check_error_r & input_check_error_flag);

  always @(posedge clk) begin
    if (reset) begin
      alarm_internal <= 1'b0;
    end else if (ce) begin
      alarm_internal <= alarm_nxt;
    end
  end

  alarm_pin_shaper u_alarm_pin_shaper (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .alert_in(alarm_internal),
    .polarity(alarm_pol_r),
    .pin_level(alarm_pin_level)
  );

  always @* begin
    alarm_route = 8'h00;
    for (i = 0; i < `NUM_CH; i = i + 1) begin
      alarm_route[i] = (alarm_pin_r == i[3:0]);
    end
  end

  // pin type 1 = general pin; direction 1 = digital output
  assign digital_out = pin_type_bits & pin_dir_bits;
  assign pin_drive_en = digital_out;
  assign pin_drive = (alarm_route & {8{alarm_pin_level}})
                   | (~alarm_route & output_level_bits_r);

endmodule // adc_channel_regs

// [testbench/host_model.sv]
/*
  Host model: single-byte register writes and reads over the strobe port.
  Assumes strobes are taken on the rising edge and read data follows one cycle later.
*/
`timescale 1ns/1ps
module host_model (
  input wire clk,
  input wire [7:0] reg_rdata,
  output reg reg_wr,
  output reg reg_rd,
  output reg [7:0] reg_addr,
  output reg [7:0] reg_wdata
);
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
  ////////////////////////////////////////
  // one strobe cycle per transfer, idle cycle between transfers
  task wr(input [7:0] a, input [7:0] v);
    begin
      @(negedge clk);
      reg_wr = 1'h1;
      reg_addr = a;
      reg_wdata = v;
      @(negedge clk);
      reg_wr = 1'h0;
      reg_addr = ~a;
      reg_wdata = ~v;
    end
  endtask
  task rd(input [7:0] a, output [7:0] v);
    begin
      @(negedge clk);
      reg_rd = 1'h1;
      reg_addr = a;
      @(negedge clk);
      reg_rd = 1'h0;
      reg_addr = ~a;
      v = reg_rdata;
    end
  endtask
endmodule // host_model

// [testbench/adc_channel_regs_monitor.sv]
/*
  Assertion checker for the channel register bank.
  Assumes it is bound to adc_channel_regs and sees only its ports.
*/
`timescale 1ns/1ps
`include "adc_regs_defs.vh"
module adc_channel_regs_monitor (
  input wire clk,
  input wire reset,
  input wire ce,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire [7:0] pin_type_bits,
  input wire [7:0] pin_dir_bits,
  input wire [7:0] pin_level_in,
  input wire [7:0] event_flags,
  input wire input_check_error_flag,
  input wire conv_done,
  input wire [3:0] on_the_fly_channel_id,
  input wire [7:0] pin_drive,
  input wire [7:0] pin_drive_en,
  input wire [3:0] conv_channel,
  input wire conv_channel_valid,
  input wire scan_running,
  input wire alarm_internal
);
  reg [7:0] olv_r, pin_r, amask_r;
  reg crc_en_r;
  wire [7:0] route = pin_r[7] ? 8'h00 : 8'h01 << pin_r[6:4];
  wire alarm_nxt = |(event_flags & amask_r) | (crc_en_r & input_check_error_flag);
  // shadow of the registers that steer alarm and pins
  always @(posedge clk) begin
    if (reset) begin
      {olv_r, pin_r, amask_r, crc_en_r} <= 25'h0;
    end else if (ce && reg_wr) begin
      if (reg_addr == `ADDR_OUTPUT_LEVEL_SET) olv_r <= reg_wdata;
      if (reg_addr == `ADDR_ALARM_PIN_SETUP) pin_r <= reg_wdata;
      if (reg_addr == `ADDR_ALARM_CH_MASK) amask_r <= reg_wdata;
      if (reg_addr == `ADDR_ALARM_SOURCE) crc_en_r <= reg_wdata[0];
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property p_drive_en; pin_drive_en == (pin_type_bits & pin_dir_bits); endproperty
  a_drive_en: assert property (p_drive_en) else $error("drive enable wrong");
  property p_pin_out; ((pin_drive ^ olv_r) & ~route) == 8'h00; endproperty
  a_pin_out: assert property (p_pin_out) else $error("pin level wrong");
  property p_alarm; $past(ce) && !$past(reset) |-> alarm_internal == $past(alarm_nxt); endproperty
  a_alarm: assert property (p_alarm) else $error("alarm wrong");
  property p_readback;
    ce && $past(ce) && !$past(reset) && reg_rd && reg_addr == `ADDR_INPUT_LEVEL
      |=> reg_rdata == $past(pin_level_in, 2);
  endproperty
  a_readback: assert property (p_readback) else $error("readback wrong");
  property p_unmapped; ce && reg_rd && reg_addr == 8'h0e |=> reg_rdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
  property p_reset;
    disable iff (1'b0) reset |=> reg_rdata == `REG_RESET && !scan_running && !alarm_internal;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");
  property p_valid; conv_channel_valid |-> !conv_channel[3]; endproperty
  a_valid: assert property (p_valid) else $error("reserved id valid");
  property p_hold;
    scan_running && $past(scan_running, 2) && !conv_done && !$past(conv_done) && !reg_wr
      && !$past(reg_wr) && !$past(reg_wr, 2) |=> $stable(conv_channel);
  endproperty
  a_hold: assert property (p_hold) else $error("scan channel moved");
  c_scan: cover property ($rose(scan_running));
  c_alarm: cover property ($rose(alarm_internal));
  c_step: cover property (scan_running && conv_done);
endmodule // adc_channel_regs_monitor
bind adc_channel_regs adc_channel_regs_monitor u_adc_channel_regs_monitor (.*);

// [testbench/test_adc_channel_regs.sv]
/*
  Self-checking bench for the channel register bank.
  Assumes the host model drives the strobe port; other inputs change on the falling edge.
*/
`timescale 1ns/1ps
`include "adc_regs_defs.vh"
module test_adc_channel_regs;
  reg clk = 0, reset = 1, ce = 1, conv_done = 0, input_check_error_flag = 0;
  reg [7:0] pin_type_bits = 0, pin_dir_bits = 0, pin_level_in = 0, event_flags = 0;
  reg [3:0] on_the_fly_channel_id = 0;
  wire reg_wr, reg_rd, conv_channel_valid, scan_running, alarm_internal;
  wire [7:0] reg_addr, reg_wdata, reg_rdata, pin_drive, pin_drive_en;
  wire [3:0] conv_channel;
  integer err_count = 0, checks = 0, i, n, cnt;
  reg [31:0] seed = 32'h2868;
  reg [7:0] d;
  reg ev;
  localparam [71:0] ADDRS = {8'h0b, 8'h0d, 8'h0e, 8'h10, 8'h11, 8'h12, 8'h14, 8'h16, 8'h17};
  localparam [15:0] SEQ = {4'h2, 4'h7, 4'h5, 4'h2};
`define CHK(a, b) begin checks = checks + 1; if ((a) !== (b)) begin err_count = err_count + 1; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
  always #5 clk = ~clk;
  host_model u_host_model (.*);
  adc_channel_regs u_adc_channel_regs (.*);
  ////////////////////////////////////////
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  function [7:0] rw_mask(input [7:0] a);
    case (a)
      8'h10: rw_mask = 8'h13;
      8'h11: rw_mask = 8'h0f;
      8'h16: rw_mask = 8'h01;
      8'h17: rw_mask = 8'hf3;
      8'h0b, 8'h12, 8'h14: rw_mask = 8'hff;
      default: rw_mask = 8'h00;
    endcase
  endfunction
  task rd_chk(input [7:0] a, input [7:0] e);
    begin
      u_host_model.rd(a, d);
      `CHK(d, e)
    end
  endtask
  task conclude;
    begin
      $display("errors %0d checks %0d", err_count, checks);
      if (err_count == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  initial begin
    #100000;
    err_count = err_count + 1;
    conclude;
  end
  initial begin
    repeat (8) @(negedge clk);
    reset = 0;
    for (i = 0; i < 9; i = i + 1) rd_chk(ADDRS[8*i +: 8], `REG_RESET);
    for (n = 0; n < 36; n = n + 1) begin
      seed = xs(seed);
      u_host_model.wr(ADDRS[8*(n%9) +: 8], seed[7:0]);
      rd_chk(ADDRS[8*(n%9) +: 8], seed[7:0] & rw_mask(ADDRS[8*(n%9) +: 8]));
    end
    u_host_model.wr(8'h17, 8'h80);
    for (n = 0; n < 8; n = n + 1) begin
      seed = xs(seed);
      {pin_type_bits, pin_dir_bits, pin_level_in} = seed[23:0];
      u_host_model.wr(8'h0b, seed[31:24]);
      `CHK(pin_drive, seed[31:24])
      `CHK(pin_drive_en, pin_type_bits & pin_dir_bits)
      rd_chk(8'h0d, pin_level_in);
    end
    // single channels stay analog inputs
    pin_type_bits = 8'h00;
    u_host_model.wr(8'h12, 8'h00);
    on_the_fly_channel_id = 4'h3;
    for (n = 0; n < 4; n = n + 1) begin
      u_host_model.wr(8'h10, n[7:0]);
      for (i = 0; i < 16; i = i + 1) begin
        u_host_model.wr(8'h11, i[7:0]);
        repeat (2) @(negedge clk);
        ev = (n == 0 && !i[3]) || n == 2;
        `CHK(conv_channel_valid, ev)
        if (ev) `CHK(conv_channel, (n == 2) ? 4'h3 : i[3:0])
      end
    end
    u_host_model.wr(8'h12, 8'ha4);
    u_host_model.wr(8'h10, 8'h11);
    repeat (2) @(negedge clk);
    `CHK(scan_running, 1'h1)
    for (n = 0; n < 4; n = n + 1) begin
      `CHK(conv_channel, SEQ[4*n +: 4])
      conv_done = 1;
      @(negedge clk);
      conv_done = 0;
      @(negedge clk);
    end
    u_host_model.wr(8'h10, 8'h01);
    repeat (2) @(negedge clk);
    `CHK(scan_running, 1'h0)
    // a write while the clock enable is low must not land
    u_host_model.wr(8'h14, 8'h5a);
    ce = 0;
    u_host_model.wr(8'h14, 8'ha5);
    ce = 1;
    rd_chk(8'h14, 8'h5a);
    // alarm channel 0 is a general pin driven as output
    {pin_type_bits, pin_dir_bits} = 16'h0101;
    u_host_model.wr(8'h14, 8'h04);
    u_host_model.wr(8'h17, 8'h01);
    for (n = 0; n < 8; n = n + 1) begin
      u_host_model.wr(8'h16, {7'h0, n[1]});
      {input_check_error_flag, event_flags} = {n[0], 8'h01 << n};
      repeat (3) @(negedge clk);
      `CHK(alarm_internal, n == 2 || (n[0] && n[1]))
      `CHK(pin_drive[0], n == 2 || (n[0] && n[1]))
    end
    input_check_error_flag = 0;
    u_host_model.wr(8'h17, 8'h03);
    // let any pulse started in level mode run out first
    repeat (110) @(negedge clk);
    event_flags = 8'h04;
    cnt = 0;
    for (n = 0; n < 150; n = n + 1) begin
      @(negedge clk);
      cnt = cnt + pin_drive[0];
    end
    `CHK(cnt, `ALARM_PULSE_CYCLES)
    u_host_model.wr(8'h17, 8'h00);
    repeat (3) @(negedge clk);
    `CHK(pin_drive[0], 1'h0)
    event_flags = 8'h00;
    repeat (3) @(negedge clk);
    `CHK(pin_drive[0], 1'h1)
    u_host_model.wr(8'h17, 8'h02);
    repeat (3) @(negedge clk);
    event_flags = 8'h04;
    cnt = 0;
    for (n = 0; n < 150; n = n + 1) begin
      @(negedge clk);
      cnt = cnt + (pin_drive[0] ? 0 : 1);
    end
    `CHK(cnt, `ALARM_PULSE_CYCLES)
    conclude;
  end
endmodule // test_adc_channel_regs
